// ==== src/exc_timer_pkg.sv ====
// shared types and constants for the excitation period timer
package exc_timer_pkg;

  localparam int unsigned CNT_WIDTH       = 16;
  localparam int unsigned CLK_PERIOD_PS   = 25000;  // converter core clock, 25 ns
  localparam int unsigned CYCLE_OFFSET    = 1;      // cycle = (capture + 1) * period
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE   = 16'h0001;
  localparam logic [CNT_WIDTH-1:0] CAP_RESET = 16'hFFFF;

  // self-test identifiers
  localparam int unsigned TEST_COUNT = 9;
  localparam int unsigned T_ADC      = 0;  // adc_self_test
  localparam int unsigned T_SIGERR   = 1;
  localparam int unsigned T_DISC     = 2;
  localparam int unsigned T_PWRSHORT = 3;
  localparam int unsigned T_GNDSHORT = 4;
  localparam int unsigned T_AMPHIGH  = 5;
  localparam int unsigned T_AMPLOW   = 6;
  localparam int unsigned T_ANGLE    = 7;  // power start-up only
  localparam int unsigned T_CONVERR  = 8;  // power start-up only
  localparam logic [TEST_COUNT-1:0] SHORT_MASK   = 9'h07F;
  localparam logic [TEST_COUNT-1:0] STARTUP_MASK = 9'h180;
  localparam logic [TEST_COUNT-1:0] TEST_NONE    = 9'h000;

  // self-test sequencing phase
  typedef enum logic [1:0] {
    PH_STARTUP_LONG  = 2'b00,  // power start-up, long tests allowed
    PH_STARTUP_SHORT = 2'b01,  // power start-up, short tests begun
    PH_CONVERSION    = 2'b10   // angle conversion running
  } phase_type;

  // software-facing timer control
  typedef struct packed {
    logic                 edge_falling;              // 0: rising, 1: falling
    logic                 interrupt_request_enable;
    logic                 cap_write;                 // one-cycle load strobe
    logic [CNT_WIDTH-1:0] cap_wdata;
  } timer_ctrl_type;

  // module state
  typedef struct packed {
    logic                  zc_prev;
    logic [CNT_WIDTH-1:0]  period_count;
    logic [CNT_WIDTH-1:0]  excitation_period_capture;
    logic                  capture_pulse;
    logic                  irq;
    phase_type             phase;
    logic [TEST_COUNT-1:0] grant;
    logic                  order_error;
  } state_type;

  // excitation cycle in picoseconds from a captured value
  function automatic logic [47:0] cycle_ps(input logic [CNT_WIDTH-1:0] cap);
    cycle_ps = (48'(cap) + 48'(CYCLE_OFFSET)) * 48'(CLK_PERIOD_PS);
  endfunction

endpackage

// ==== src/resolver_excitation_period_timer.sv ====
// excitation period timer with self-test sequencing gate
`timescale 1ns/100ps

// Notes on behaviour
// - active edge captures period counter for software
// - software picks rising or falling capture edge
// - cycle equals capture plus one, times 25ns
// - enabled interrupt when counter equals capture value
// - short tests allowed in conversion and start-up, refused alongside long ones before short tests begin
// - angle and conversion-error tests start-up only
module resolver_excitation_period_timer
  import exc_timer_pkg::*;
(
  // clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  // zero-crossing comparator
  input  wire logic                  ZERO_CROSS,
  // timer control
  input  wire timer_ctrl_type        TIMER_CTRL,
  // timer status
  output logic [CNT_WIDTH-1:0]       EXCITATION_PERIOD_CAPTURE,
  output logic [CNT_WIDTH-1:0]       PERIOD_COUNT,
  output logic                       CAPTURE_PULSE,
  output logic [47:0]                CYCLE_PS,
  output logic                       EXC_TIMER_IRQ,
  // self-test sequencing
  input  wire logic                  START_CONVERSION,
  input  wire logic [TEST_COUNT-1:0] TEST_REQUEST,
  output logic [TEST_COUNT-1:0]      TEST_GRANT,
  output logic                       TEST_ORDER_ERROR,
  output logic [1:0]                 TEST_PHASE
);

  state_type state_reg;
  state_type state_next;

  // selected edge of the comparator level
  function automatic logic edge_seen(
    input logic previous,
    input logic current,
    input logic falling
  );
    if (falling) begin
      edge_seen = previous & ~current;
    end else begin
      edge_seen = ~previous & current;
    end
  endfunction

  // period counter step, wraps at full scale
  function automatic logic [CNT_WIDTH-1:0] count_step(
    input logic [CNT_WIDTH-1:0] count
  );
    count_step = count + CNT_ONE;
  endfunction

  // counter restarts on the captured edge
  function automatic logic [CNT_WIDTH-1:0] count_next(
    input logic                 hit,
    input logic [CNT_WIDTH-1:0] count
  );
    if (hit) begin
      count_next = CNT_ZERO;
    end else begin
      count_next = count_step(count);
    end
  endfunction

  // capture register next value, an edge beats a software load
  function automatic logic [CNT_WIDTH-1:0] capture_next(
    input logic                 hit,
    input logic [CNT_WIDTH-1:0] count,
    input logic [CNT_WIDTH-1:0] held,
    input logic                 load,
    input logic [CNT_WIDTH-1:0] load_value
  );
    if (hit) begin
      capture_next = count;
    end else if (load) begin
      capture_next = load_value;
    end else begin
      capture_next = held;
    end
  endfunction

  // counter reached the capture value while enabled
  function automatic logic match_hit(
    input logic                 enable,
    input logic [CNT_WIDTH-1:0] count,
    input logic [CNT_WIDTH-1:0] held
  );
    match_hit = enable && (count == held);
  endfunction

  // any requested test inside a group
  function automatic logic any_in(
    input logic [TEST_COUNT-1:0] request,
    input logic [TEST_COUNT-1:0] group
  );
    any_in = ((request & group) != TEST_NONE);
  endfunction

  // short and long tests asked for together
  function automatic logic mixed_request(
    input logic [TEST_COUNT-1:0] request
  );
    mixed_request = any_in(request, SHORT_MASK) && any_in(request, STARTUP_MASK);
  endfunction

  // tests that the current phase lets through
  function automatic logic [TEST_COUNT-1:0] allowed_tests(
    input phase_type             phase,
    input logic [TEST_COUNT-1:0] request
  );
    allowed_tests = TEST_NONE;
    unique case (phase)
      PH_STARTUP_LONG: begin
        if (mixed_request(request)) begin
          allowed_tests = STARTUP_MASK;
        end else begin
          allowed_tests = SHORT_MASK | STARTUP_MASK;
        end
      end
      PH_STARTUP_SHORT: begin
        allowed_tests = SHORT_MASK;
      end
      PH_CONVERSION: begin
        allowed_tests = SHORT_MASK;
      end
      default: begin
        allowed_tests = TEST_NONE;
      end
    endcase
  endfunction

  // phase after this cycle's requests and start strobe
  function automatic phase_type phase_after(
    input phase_type             phase,
    input logic [TEST_COUNT-1:0] request,
    input logic                  start
  );
    phase_after = phase;
    unique case (phase)
      PH_STARTUP_LONG: begin
        if (start) begin
          phase_after = PH_CONVERSION;
        end else if (any_in(request, SHORT_MASK) && !mixed_request(request)) begin
          phase_after = PH_STARTUP_SHORT;
        end
      end
      PH_STARTUP_SHORT: begin
        if (start) begin
          phase_after = PH_CONVERSION;
        end
      end
      PH_CONVERSION: begin
        phase_after = PH_CONVERSION;
      end
      default: begin
        phase_after = PH_CONVERSION;  // illegal code recovers
      end
    endcase
  endfunction

  // next-state logic
  always_comb begin
    logic                  edge_hit;
    logic [TEST_COUNT-1:0] allowed;
    edge_hit   = edge_seen(state_reg.zc_prev, ZERO_CROSS, TIMER_CTRL.edge_falling);
    allowed    = allowed_tests(state_reg.phase, TEST_REQUEST);
    state_next = state_reg;
    // comparator level kept for edge detection
    state_next.zc_prev       = ZERO_CROSS;
    state_next.capture_pulse = edge_hit;
    // counter and capture register
    state_next.period_count  = count_next(edge_hit, state_reg.period_count);
    state_next.excitation_period_capture = capture_next(edge_hit, state_reg.period_count,
                                                        state_reg.excitation_period_capture,
                                                        TIMER_CTRL.cap_write, TIMER_CTRL.cap_wdata);
    // match interrupt, one cycle per matching count
    state_next.irq = match_hit(TIMER_CTRL.interrupt_request_enable, state_reg.period_count,
                               state_reg.excitation_period_capture);
    // self-test gate and sequencing
    state_next.phase       = phase_after(state_reg.phase, TEST_REQUEST, START_CONVERSION);
    state_next.grant       = TEST_REQUEST & allowed;
    // refused requests leave a sticky flag
    state_next.order_error = state_reg.order_error | any_in(TEST_REQUEST, ~allowed);
  end

  // state register
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      // counter from zero, capture at full scale, start-up phase
      state_reg.zc_prev                   <= 1'b0;
      state_reg.period_count              <= CNT_ZERO;
      state_reg.excitation_period_capture <= CAP_RESET;
      state_reg.capture_pulse             <= 1'b0;
      state_reg.irq                       <= 1'b0;
      state_reg.phase                     <= PH_STARTUP_LONG;
      state_reg.grant                     <= TEST_NONE;
      state_reg.order_error               <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // capture and counter outputs
  assign EXCITATION_PERIOD_CAPTURE = state_reg.excitation_period_capture;
  assign PERIOD_COUNT              = state_reg.period_count;
  assign CAPTURE_PULSE             = state_reg.capture_pulse;
  assign CYCLE_PS                  = cycle_ps(state_reg.excitation_period_capture);

  // interrupt output
  assign EXC_TIMER_IRQ             = state_reg.irq;

  // self-test outputs
  assign TEST_GRANT                = state_reg.grant;
  assign TEST_ORDER_ERROR          = state_reg.order_error;
  assign TEST_PHASE                = state_reg.phase;

endmodule // resolver_excitation_period_timer

// ==== testbench/exc_timer_assertions.sv ====
// port checker for the excitation period timer
`timescale 1ns/100ps
module exc_timer_checker
  import exc_timer_pkg::*;
(
  // clock and reset
  input wire logic                  MCLK,
  input wire logic                  RESET,
  // timer side
  input wire logic                  ZERO_CROSS,
  input wire timer_ctrl_type        TIMER_CTRL,
  input wire logic [CNT_WIDTH-1:0]  EXCITATION_PERIOD_CAPTURE,
  input wire logic [CNT_WIDTH-1:0]  PERIOD_COUNT,
  input wire logic                  CAPTURE_PULSE,
  input wire logic [47:0]           CYCLE_PS,
  input wire logic                  EXC_TIMER_IRQ,
  // self-test side
  input wire logic                  START_CONVERSION,
  input wire logic [TEST_COUNT-1:0] TEST_REQUEST,
  input wire logic [TEST_COUNT-1:0] TEST_GRANT,
  input wire logic                  TEST_ORDER_ERROR,
  input wire logic [1:0]            TEST_PHASE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // capture, counter and interrupt timing, self-test grants by phase
  rise_capture_a: assert property (!TIMER_CTRL.edge_falling && $rose(ZERO_CROSS) |=> CAPTURE_PULSE &&
    PERIOD_COUNT == 16'h0000 && EXCITATION_PERIOD_CAPTURE == $past(PERIOD_COUNT)) else $error("bad capture");
  fall_capture_a: assert property (TIMER_CTRL.edge_falling && $fell(ZERO_CROSS) |=> CAPTURE_PULSE)
    else $error("no capture on fall");
  wrong_edge_a: assert property (!TIMER_CTRL.edge_falling && $fell(ZERO_CROSS) |=> !CAPTURE_PULSE)
    else $error("capture on wrong edge");
  count_step_a: assert property (!$past(RESET) && !CAPTURE_PULSE |-> PERIOD_COUNT == 16'($past(PERIOD_COUNT) + 16'h1))
    else $error("counter did not step");
  cycle_value_a: assert property (CYCLE_PS == (48'(EXCITATION_PERIOD_CAPTURE) + 48'h1) * 48'h61A8)
    else $error("cycle value wrong");
  irq_match_a: assert property (TIMER_CTRL.interrupt_request_enable && PERIOD_COUNT == EXCITATION_PERIOD_CAPTURE
    |=> EXC_TIMER_IRQ) else $error("missing interrupt");
  irq_masked_a: assert property (!TIMER_CTRL.interrupt_request_enable |=> !EXC_TIMER_IRQ) else $error("masked irq");
  long_blocked_a: assert property (TEST_PHASE != 2'h0 |=> TEST_GRANT[8:7] == 2'h0) else $error("long test late");
  short_grant_a: assert property (TEST_PHASE == 2'h2 |=> TEST_GRANT == ($past(TEST_REQUEST) & 9'h07F))
    else $error("short test grant wrong");
  // self-test ordering and phase
  mixed_order_a: assert property (TEST_PHASE == 2'h0 && (TEST_REQUEST & SHORT_MASK) != TEST_NONE
    && (TEST_REQUEST & STARTUP_MASK) != TEST_NONE
    |=> TEST_ORDER_ERROR && TEST_GRANT == ($past(TEST_REQUEST) & STARTUP_MASK))
    else $error("mixed request not refused");
  order_sticky_a: assert property (TEST_ORDER_ERROR |=> TEST_ORDER_ERROR) else $error("order flag dropped");
  start_phase_a: assert property (START_CONVERSION |=> TEST_PHASE == 2'h2) else $error("no conversion phase");
endmodule // exc_timer_checker

bind resolver_excitation_period_timer exc_timer_checker u_chk (.*);

// ==== testbench/zero_cross_model.sv ====
// comparator model: square wave of programmable half period
`timescale 1ns/100ps
module zero_cross_model (
  // clock and control
  input wire logic       MCLK,
  input wire logic       run,
  input wire logic [7:0] half,
  // comparator output
  output logic           zc
);
  logic [7:0] cnt_reg = 8'h00;
  initial zc = 1'b0;
  // toggle every half period, hold level when stopped
  always @(posedge MCLK) begin
    if (run) begin
      cnt_reg <= (cnt_reg + 8'h01 >= half) ? 8'h00 : cnt_reg + 8'h01;
      if (cnt_reg + 8'h01 >= half) zc <= ~zc;
    end
  end
endmodule // zero_cross_model

// ==== testbench/resolver_excitation_period_timer_tb_top.sv ====
// testbench for the excitation period timer
`timescale 1ns/100ps
module resolver_excitation_period_timer_tb_top
  import exc_timer_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, zc, start = 1'b0, run = 1'b0, pulse, irq, oerr;
  logic [7:0] half = 8'h04;
  timer_ctrl_type ctrl = '0;
  logic [8:0] treq = 9'h000, grant, s;
  logic [15:0] cap, cnt, v;
  logic [47:0] cyc;
  logic [1:0] phase;
  logic [31:0] seed = 32'h00008BE6;
  int num_errors = 0, check_count = 0, i, k;
  zero_cross_model partner (.MCLK(mclk), .run(run), .half(half), .zc(zc));
  resolver_excitation_period_timer DUT (.MCLK(mclk), .RESET(reset), .ZERO_CROSS(zc), .TIMER_CTRL(ctrl),
    .EXCITATION_PERIOD_CAPTURE(cap), .PERIOD_COUNT(cnt), .CAPTURE_PULSE(pulse), .CYCLE_PS(cyc), .EXC_TIMER_IRQ(irq),
    .START_CONVERSION(start), .TEST_REQUEST(treq), .TEST_GRANT(grant), .TEST_ORDER_ERROR(oerr), .TEST_PHASE(phase));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // compare and count
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded wait for capture pulse (0) or interrupt (1)
  task automatic wait_hi(input int sel);
    for (k = 0; k < 600; k++) begin
      @(negedge mclk);
      if ((sel ? irq : pulse) === 1'b1) return;
    end
    num_errors++;
    $display("unexpected %0t wait timed out", $time);
    finish_test();
  endtask
  // one self-test request, grant seen the cycle after
  task automatic req(input logic [8:0] r, input logic [8:0] exp);
    @(posedge mclk) treq <= r;
    @(posedge mclk) treq <= 9'h000;
    @(negedge mclk) chk(48'(grant), 48'(exp));
  endtask
  initial forever #12.5 mclk = ~mclk;
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    run <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge mclk);
      ctrl.edge_falling <= i[0];
      half <= 8'h02 + 8'(rnd() % 40);
      repeat (3) wait_hi(0);
      chk(48'(cap), 48'(2 * half - 1));
      chk(cyc, 48'(2 * half) * 48'h61A8);
    end
    // excitation stops; loaded limit must raise the interrupt
    v = 16'h0100 + 16'(rnd() % 64);
    @(posedge mclk) run <= 1'b0;
    repeat (2) @(posedge mclk);
    ctrl <= '{1'b1, 1'b0, 1'b1, v};
    @(posedge mclk) ctrl <= '{1'b1, 1'b1, 1'b0, v};
    wait_hi(1);
    chk(48'(cnt), 48'(v) + 48'h1);
    // long tests, then short, then a refused long one
    req(9'h180, 9'h180);
    s = 9'h07F & 9'(rnd()) | 9'h001;
    req(s, s);
    req(9'h100, 9'h000);
    chk(48'(oerr), 48'h1);
    @(posedge mclk) start <= 1'b1;
    @(posedge mclk) start <= 1'b0;
    for (i = 0; i < 8; i++) begin
      s = 9'(rnd());
      req(s, s & 9'h07F);
    end
    chk(48'(phase), 48'h2);
    // mid-run reset, then short and long asked together
    @(posedge mclk) reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk(48'(oerr), 48'h0);
    chk(48'(phase), 48'h0);
    chk(48'(cap), 48'(CAP_RESET));
    req(9'h181, 9'h180);
    chk(48'(oerr), 48'h1);
    chk(48'(phase), 48'h0);
    finish_test();
  end
endmodule // resolver_excitation_period_timer_tb_top
